// ---- design/pin_mux_pkg.sv ----
// Constants, pin tables and carrier types for the pin function multiplexer
package pin_mux_pkg;
  localparam int NPIN  = 10;
  localparam int NPORT = 4;
  localparam int PW    = 12;
  localparam int AW    = 6;
  localparam int DW    = 16;
  localparam int CFG_W = 9;

  localparam int CLK_NS          = 25;
  localparam int GPIO_GLITCH_NS  = 10;
  localparam int GPIO_REJECT_CYC = (GPIO_GLITCH_NS + CLK_NS - 1) / CLK_NS;
  localparam int DPD_GLITCH_NS   = 20;
  localparam int DPD_REJECT_CYC  = (DPD_GLITCH_NS + CLK_NS - 1) / CLK_NS;
  localparam int WAKE_PULSE_NS   = 50;
  localparam int WAKE_CYC        = WAKE_PULSE_NS / CLK_NS;
  // Samples that must agree; one more than the longest rejected glitch
  localparam int FILT_DEPTH      = DPD_REJECT_CYC + 1;

  localparam int CFG_FUNC_LSB   = 0;
  localparam int CFG_PULL_LSB   = 2;
  localparam int CFG_HYST_BIT   = 4;
  localparam int CFG_OD_BIT     = 5;
  localparam int CFG_ISENSE_BIT = 6;
  localparam int CFG_IBOTH_BIT  = 7;
  localparam int CFG_IHIGH_BIT  = 8;
  localparam logic [CFG_W-1:0] CFG_RESET = 9'h008;

  typedef enum logic [1:0] {
    FUNC_GPIO   = 2'h0,
    FUNC_ALT    = 2'h1,
    FUNC_ANALOG = 2'h2
  } func_t;

  typedef enum logic [1:0] {
    PULL_NONE = 2'h0,
    PULL_DOWN = 2'h1,
    PULL_UP   = 2'h2
  } pull_t;

  localparam logic [AW-1:0] A_CFG_LAST = 6'h09;
  localparam logic [AW-1:0] A_DATA     = 6'h10;
  localparam logic [AW-1:0] A_DIR      = 6'h18;
  localparam logic [AW-1:0] A_STAT     = 6'h20;
  localparam logic [AW-1:0] A_CLR      = 6'h21;
  localparam logic [AW-1:0] A_EN       = 6'h22;
  localparam logic [AW-1:0] A_START    = 6'h23;
  localparam logic [AW-1:0] A_LEVEL    = 6'h24;

  localparam logic [1:0] PIN_PORT [NPIN] =
    '{2'h1, 2'h1, 2'h1, 2'h1, 2'h1, 2'h2, 2'h3, 2'h3, 2'h3, 2'h0};
  localparam logic [3:0] PIN_BIT [NPIN] =
    '{4'h4, 4'h8, 4'h9, 4'ha, 4'hb, 4'h0, 4'h2, 4'h4, 4'h5, 4'h4};
  localparam logic [PW-1:0] PORT_IMPL [NPORT] =
    '{12'h010, 12'hf10, 12'h001, 12'h034};
  localparam logic [NPIN-1:0] ALT_MASK   = 10'h22f;
  localparam logic [NPIN-1:0] ANA_MASK   = 10'h019;
  localparam logic [NPIN-1:0] OD_MASK    = 10'h200;
  localparam logic [NPIN-1:0] START_MASK = 10'h0e0;

  typedef struct packed {
    logic out;
    logic oe;
    logic pull_up;
    logic pull_down;
    logic hyst;
    logic analog;
  } pad_ctrl_t;

  typedef struct packed {
    logic          wr;
    logic          rd;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
  } reg_req_t;
endpackage : pin_mux_pkg

// ---- design/pin_function_mux_wake.sv ----
// Pin function multiplexer with pad control, pin interrupts and deep power-down wake
`timescale 1ns/1ps
module pin_function_mux_wake (
  input  logic                              clk,
  input  logic                              reset_n,
  input  pin_mux_pkg::reg_req_t             reg_req,
  output logic [pin_mux_pkg::DW-1:0]        rdata,
  input  logic [pin_mux_pkg::NPIN-1:0]      pad_in,
  output pin_mux_pkg::pad_ctrl_t            pad [pin_mux_pkg::NPIN],
  input  logic [pin_mux_pkg::NPIN-1:0]      alt_out,
  input  logic [pin_mux_pkg::NPIN-1:0]      alt_oe,
  output logic [pin_mux_pkg::NPIN-1:0]      alt_in,
  output logic [pin_mux_pkg::NPIN-1:0]      analog_sel,
  input  logic                              ext_reset_n,
  input  logic                              dpd,
  output logic                              chip_reset_req,
  output logic                              wake_req,
  output logic                              gpio_irq,
  output logic [pin_mux_pkg::NPIN-1:0]      start_out
);
  import pin_mux_pkg::*;

  logic [CFG_W-1:0]      cfg      [NPIN];
  logic [PW-1:0]         pdata    [NPORT];
  logic [PW-1:0]         pdir     [NPORT];
  logic [PW-1:0]         pin_view [NPORT];
  logic [PW-1:0]         pread    [NPORT];
  logic [FILT_DEPTH-1:0] hist     [NPIN];
  logic [NPIN-1:0]       filt;
  logic [NPIN-1:0]       prev;
  logic [NPIN-1:0]       digi_in;
  logic [NPIN-1:0]       ev;
  logic [NPIN-1:0]       sel_alt;
  logic [NPIN-1:0]       int_stat;
  logic [NPIN-1:0]       int_en;
  logic [NPIN-1:0]       start_en;
  logic [DW-1:0]         next_rdata;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode
  wire           wr     = reg_req.wr;
  wire [AW-1:0]  addr   = reg_req.addr;
  wire [DW-1:0]  wdata  = reg_req.wdata;
  wire           is_cfg  = addr <= A_CFG_LAST;
  wire           is_data = addr[AW-1:2] == A_DATA[AW-1:2];
  wire           is_dir  = addr[AW-1:2] == A_DIR[AW-1:2];
  wire [NPIN-1:0] clr_mask = (wr && addr == A_CLR) ? wdata[NPIN-1:0] : '0;

  assign next_rdata =
    is_cfg           ? DW'(cfg[addr[3:0]]) :
    is_data          ? DW'(pread[addr[1:0]]) :
    is_dir           ? DW'(pdir[addr[1:0]]) :
    addr == A_STAT   ? DW'(int_stat) :
    addr == A_EN     ? DW'(int_en) :
    addr == A_START  ? DW'(start_en) :
    addr == A_LEVEL  ? DW'(digi_in) :
    '0;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata <= '0;
    end else begin
      rdata <= reg_req.rd ? next_rdata : '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Port data and direction; absent bits are masked on every write
  for (genvar p = 0; p < NPORT; p++) begin : g_port
    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        pdata[p] <= '0;
        pdir[p]  <= '0;
      end else begin
        if (wr && is_data && addr[1:0] == 2'(p)) begin
          pdata[p] <= wdata[PW-1:0] & PORT_IMPL[p];
        end
        if (wr && is_dir && addr[1:0] == 2'(p)) begin
          pdir[p] <= wdata[PW-1:0] & PORT_IMPL[p];
        end
      end
    end
    // Output bits read back the latch, input bits the filtered pin
    assign pread[p] = ((pdir[p] & pdata[p]) | (~pdir[p] & pin_view[p]))
                      & PORT_IMPL[p];
  end

  always_comb begin
    for (int p = 0; p < NPORT; p++) begin
      pin_view[p] = '0;
    end
    for (int i = 0; i < NPIN; i++) begin
      pin_view[PIN_PORT[i]][PIN_BIT[i]] = digi_in[i];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-pin multiplexer, pad control, glitch filter and event detect
  for (genvar i = 0; i < NPIN; i++) begin : g_pin
    wire [1:0] func   = cfg[i][CFG_FUNC_LSB +: 2];
    wire [1:0] pull   = cfg[i][CFG_PULL_LSB +: 2];
    wire       ana    = func == FUNC_ANALOG && ANA_MASK[i];
    wire       alt    = func == FUNC_ALT && ALT_MASK[i];
    wire       od     = OD_MASK[i] || cfg[i][CFG_OD_BIT];
    wire       p_dir  = pdir[PIN_PORT[i]][PIN_BIT[i]];
    wire       p_out  = pdata[PIN_PORT[i]][PIN_BIT[i]];
    wire       d_oe   = alt ? alt_oe[i] : p_dir;
    wire       d_val  = alt ? alt_out[i] : p_out;
    wire       rise   = digi_in[i] && !prev[i];
    wire       fall   = !digi_in[i] && prev[i];
    wire       ihigh  = cfg[i][CFG_IHIGH_BIT];
    pad_ctrl_t next_pad;

    assign sel_alt[i]    = alt;
    assign analog_sel[i] = ana;
    // Open-drain drives only the low level and leaves high to the pull-up
    assign next_pad.oe        = !ana && d_oe && !(od && d_val);
    assign next_pad.out       = d_val && !od;
    assign next_pad.pull_up   = !ana && !OD_MASK[i] && pull == PULL_UP;
    assign next_pad.pull_down = !ana && !OD_MASK[i] && pull == PULL_DOWN;
    assign next_pad.hyst      = !ana && cfg[i][CFG_HYST_BIT];
    assign next_pad.analog    = ana;
    // Digital input reads low while analog, so entering analog can look like a fall
    assign digi_in[i] = filt[i] && !ana;
    // Unrouted peripheral inputs see a quiet zero, not a defined behaviour
    assign alt_in[i]  = sel_alt[i] && digi_in[i];
    assign ev[i] = cfg[i][CFG_ISENSE_BIT] ? (digi_in[i] == ihigh) :
                   cfg[i][CFG_IBOTH_BIT]  ? (rise || fall) :
                   ihigh ? rise : fall;

    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        cfg[i]  <= CFG_RESET;
        pad[i]  <= '{out: 1'b0, oe: 1'b0, pull_up: 1'b1, pull_down: 1'b0,
                     hyst: 1'b0, analog: 1'b0};
        hist[i] <= '1;
        filt[i] <= 1'b1;
        prev[i] <= 1'b1;
      end else begin
        if (wr && is_cfg && addr[3:0] == 4'(i)) begin
          cfg[i] <= wdata[CFG_W-1:0];
        end
        pad[i]  <= next_pad;
        hist[i] <= {hist[i][FILT_DEPTH-2:0], pad_in[i]};
        // Level changes only once every sample in the window agrees
        if (&hist[i]) begin
          filt[i] <= 1'b1;
        end else if (~|hist[i]) begin
          filt[i] <= 1'b0;
        end
        prev[i] <= digi_in[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt flags, start logic and deep power-down reset path
  assign gpio_irq = |(int_stat & int_en);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      int_stat       <= '0;
      int_en         <= '0;
      start_en       <= '0;
      start_out      <= '0;
      chip_reset_req <= 1'b0;
      wake_req       <= 1'b0;
    end else begin
      int_stat <= (int_stat & ~clr_mask) | ev;
      if (wr && addr == A_EN) begin
        int_en <= wdata[NPIN-1:0];
      end
      if (wr && addr == A_START) begin
        start_en <= wdata[NPIN-1:0] & START_MASK;
      end
      start_out <= ~filt & start_en & START_MASK;
      // The wake pin uses the raw filter: its digital mux may be analog
      chip_reset_req <= dpd ? !filt[0] : !ext_reset_n;
      wake_req       <= dpd && !filt[0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_wake_low;
    dpd && !pad_in[0] [*2];
  endsequence

  // One low sample between two high ones; a longer low is a real edge
  sequence s_glitch;
    pad_in[1] ##1 !pad_in[1] ##1 pad_in[1];
  endsequence

  a_third_port_absent: assert property (
    pdata[2][PW-1:1] == '0 && pdir[2][PW-1:1] == '0)
    else $error("third port absent bits hold state");
  a_fourth_port_absent: assert property (
    (pdata[3] & 12'hfcb) == '0 && (pread[3] & 12'hfcb) == '0)
    else $error("fourth port absent bits hold state");
  a_reset_pullup: assert property (
    $rose(reset_n) |-> pad[1].pull_up && !pad[1].oe && cfg[1] == CFG_RESET)
    else $error("pin not input with pull-up after reset");
  a_gpio_glitch: assert property (
    s_glitch |=> $stable(filt[1]) [*2])
    else $error("short glitch reached gpio logic");
  a_wake_pulse: assert property (
    s_wake_low ##1 dpd [*2] |=> wake_req && chip_reset_req)
    else $error("low pulse in deep power-down did not wake");
  a_reset_ignored: assert property (
    dpd && filt[0] ##1 dpd |-> !chip_reset_req)
    else $error("external reset acted in deep power-down");
  a_analog_off: assert property (
    analog_sel[0] ##1 analog_sel[0] |-> pad[0].analog && !pad[0].oe
      && !pad[0].pull_up && !digi_in[0])
    else $error("analog pad kept digital section");
  a_pull_excl: assert property (
    !(pad[1].pull_up && pad[1].pull_down))
    else $error("pull-up and pull-down both on");
  a_open_drain: assert property (
    pad[9].oe |-> !pad[9].out)
    else $error("serial bus pad drove high");
  a_one_route: assert property (
    alt_in[2] |-> cfg[2][1:0] == FUNC_ALT && !analog_sel[2])
    else $error("peripheral input routed without selection");
  a_event_sticky: assert property (
    |ev |=> (int_stat & $past(ev)) == $past(ev))
    else $error("pin event lost against clear");
  a_start_mask: assert property (
    (start_out & ~START_MASK) == '0)
    else $error("undesignated pin fed start logic");
  a_irq_line: assert property (
    $past(clr_mask) == '0 && ($past(int_stat) & int_en) != '0 |-> gpio_irq)
    else $error("enabled flag without interrupt");
endmodule : pin_function_mux_wake

// ---- test/board_model.sv ----
// Board-side model of the pads: device drive, board drive, pulls, floating lines
`timescale 1ns/1ps
module board_model (
  input  logic                         clk,
  input  pin_mux_pkg::pad_ctrl_t       pad [pin_mux_pkg::NPIN],
  input  logic [pin_mux_pkg::NPIN-1:0] ext_en,
  input  logic [pin_mux_pkg::NPIN-1:0] ext_lvl,
  output logic [pin_mux_pkg::NPIN-1:0] pad_in
);
  import pin_mux_pkg::*;
  logic flip = 1'b0;
  always @(posedge clk) begin
    flip <= ~flip;
    for (int i = 0; i < NPIN; i++) begin
      if (pad[i].oe) begin
        pad_in[i] <= pad[i].out;
      end else if (ext_en[i]) begin
        pad_in[i] <= ext_lvl[i];
      end else if (pad[i].pull_up || pad[i].pull_down) begin
        pad_in[i] <= pad[i].pull_up;
      end else begin
        // Undriven, unpulled line has no stable level
        pad_in[i] <= flip ^ i[0];
      end
    end
  end
endmodule : board_model

// ---- test/pin_function_mux_wake_tb_top.sv ----
// Self-checking bench for the pin function multiplexer
`timescale 1ns/1ps
module pin_function_mux_wake_tb_top;
  import pin_mux_pkg::*;
  logic            clk = 1'b0;
  logic            reset_n = 1'b0;
  reg_req_t        req = '0;
  logic [DW-1:0]   rdata, r;
  logic [NPIN-1:0] pad_in, alt_in, analog_sel, start_out;
  logic [NPIN-1:0] alt_out = '0;
  logic [NPIN-1:0] alt_oe = '0;
  pad_ctrl_t       pad [NPIN];
  // Board keeps the wake pin and the serial pad high by default
  logic [NPIN-1:0] ext_en = 10'h201;
  logic [NPIN-1:0] ext_lvl = 10'h3ff;
  logic            ext_reset_n = 1'b1;
  logic            dpd = 1'b0;
  logic            chip_reset_req, wake_req, gpio_irq;
  logic            rv = 1'b0;
  logic [1:0]      woke = 2'b00;
  logic [DW-1:0]   q [$];
  int              err_total = 0;
  int              n_compared = 0;
  int              cyc = 0;
  int              seed = 32'h94f8c20c;
  logic [DW-1:0]   cfgs [4] = '{16'h0008, 16'h0108, 16'h0088, 16'h0048};
  logic [2:0]      exps [4] = '{3'b100, 3'b001, 3'b101, 3'b111};

  always #12.5 clk = ~clk;

  pin_function_mux_wake u_pin_function_mux_wake (
    .clk(clk), .reset_n(reset_n), .reg_req(req), .rdata(rdata), .pad_in(pad_in),
    .pad(pad), .alt_out(alt_out), .alt_oe(alt_oe), .alt_in(alt_in),
    .analog_sel(analog_sel), .ext_reset_n(ext_reset_n), .dpd(dpd),
    .chip_reset_req(chip_reset_req), .wake_req(wake_req), .gpio_irq(gpio_irq),
    .start_out(start_out));

  board_model u_board_model (
    .clk(clk), .pad(pad), .ext_en(ext_en), .ext_lvl(ext_lvl), .pad_in(pad_in));

  ////////////////////////////////////////////////////////////
  task automatic see(input logic [DW-1:0] got, input logic [DW-1:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : see

  // A read notes its expected word; the monitor compares it a cycle later
  task automatic bus(input logic w, input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge clk);
    req <= '{wr: w, rd: !w, addr: a, wdata: d};
    if (!w) q.push_back(d);
    @(posedge clk);
    req <= '0;
  endtask : bus

  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  always @(posedge clk) rv <= req.rd && reset_n;
  always @(negedge clk) if (rv) see(rdata, q.pop_front());
  // Wake pulses last only a few cycles, so latch that they were seen
  always @(negedge clk) woke <= woke | {chip_reset_req, wake_req};
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      err_total++;
      tally_and_finish();
    end
  end

  ////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge clk);
    #2 see(16'({pad[3].pull_up, pad[3].oe}), 16'h0002);
    @(posedge clk) reset_n <= 1'b1;
    for (int i = 0; i < 9; i++) bus(0, AW'(i), 16'(CFG_RESET));
    bus(0, 6'h3f, 16'h0000);
    for (int p = 0; p < NPORT; p++) begin
      bus(1, A_DIR + AW'(p), 16'hffff);
      bus(0, A_DIR + AW'(p), 16'(PORT_IMPL[p]));
    end
    r = 16'($random(seed));
    bus(1, A_DATA + 6'h01, r);
    bus(0, A_DATA + 6'h01, r & 16'h0f10);
    see(16'({pad[1].oe, pad[1].out}), 16'({1'b1, r[8]}));
    bus(1, A_DATA, 16'h0000);
    @(posedge clk) #2 see(16'({pad[9].oe, pad[9].out}), 16'h0002);
    bus(1, A_DATA, 16'h0010);
    @(posedge clk) #2 see(16'({pad[9].oe, pad[9].pull_up}), 16'h0000);
    @(posedge clk) alt_oe <= 10'h004;
    alt_out <= 10'($random(seed));
    bus(1, 6'h02, 16'h0009);
    bus(1, 6'h00, 16'h000a);
    @(posedge clk) #2 see(16'({pad[2].oe, pad[2].out}), 16'({1'b1, alt_out[2]}));
    see(16'({analog_sel[0], pad[0].oe, pad[0].analog}), 16'h0005);
    for (int p = 0; p < NPORT; p++) bus(1, A_DIR + AW'(p), 16'h0000);
    // Only the routed pin passes its level on to the peripheral side
    #2 see(16'(alt_in), 16'(alt_out & 10'h004));
    bus(1, 6'h00, 16'h0008);
    bus(1, 6'h01, 16'h0014);
    @(posedge clk) #2 see(16'({pad[1].pull_up, pad[1].pull_down, pad[1].hyst}), 16'h0003);
    bus(1, A_EN, 16'h0002);
    ext_en[1] <= 1'b1;
    for (int m = 0; m < 4; m++) begin
      bus(1, 6'h01, cfgs[m]);
      repeat (8) @(posedge clk);
      bus(1, A_CLR, 16'h03ff);
      ext_lvl[1] <= 1'b0;
      repeat (8) @(posedge clk);
      #2 see(16'(gpio_irq), 16'(exps[m][2]));
      bus(0, A_STAT, {14'h0, exps[m][2], 1'b0});
      bus(1, A_CLR, 16'h0002);
      bus(0, A_STAT, {14'h0, exps[m][1], 1'b0});
      ext_lvl[1] <= 1'b1;
      repeat (8) @(posedge clk);
      bus(0, A_STAT, {14'h0, exps[m][0], 1'b0});
    end
    bus(1, A_EN, 16'h0000);
    #2 see(16'(gpio_irq), 16'h0000);
    bus(1, A_EN, 16'h0002);
    #2 see(16'(gpio_irq), 16'h0001);
    bus(1, A_CLR, 16'h0002);
    #2 see(16'(gpio_irq), 16'h0000);
    // One-sample low on a level-sensing pin must not reach the flag
    ext_lvl[1] <= 1'b0;
    @(posedge clk) ext_lvl[1] <= 1'b1;
    repeat (6) @(posedge clk);
    #2 see(16'(gpio_irq), 16'h0000);
    bus(1, A_START, 16'h03ff);
    bus(0, A_START, 16'h00e0);
    ext_en <= 10'h243;
    ext_lvl <= 10'h3bd;
    repeat (8) @(posedge clk);
    #2 see(16'(start_out), 16'h0040);
    bus(0, A_LEVEL, 16'(10'h3b9 | (alt_out & 10'h004)));
    ext_lvl <= 10'h3ff;
    dpd <= 1'b1;
    ext_reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    repeat (6) @(posedge clk);
    ext_lvl[0] <= 1'b0;
    @(posedge clk) ext_lvl[0] <= 1'b1;
    repeat (8) @(posedge clk);
    #2 see(16'(woke), 16'h0000);
    @(posedge clk) ext_lvl[0] <= 1'b0;
    repeat (2) @(posedge clk);
    ext_lvl[0] <= 1'b1;
    repeat (8) @(posedge clk);
    #2 see(16'(woke), 16'h0003);
    @(posedge clk) dpd <= 1'b0;
    repeat (4) @(posedge clk);
    #2 see(16'(chip_reset_req), 16'h0001);
    tally_and_finish();
  end
endmodule : pin_function_mux_wake_tb_top
